//--- hdl/cadc_params.svh
// constants for the codec adc status and output control register bank
`ifndef CADC_PARAMS_SVH
`define CADC_PARAMS_SVH

// register indices; byte address is four times the index
`define CADC_IDX_FLAGS 6'h24
`define CADC_IDX_PWR 6'h25
`define CADC_IDX_DRV 6'h26
`define CADC_IDX_RSVD 6'h27
`define CADC_IDX_STAGE 6'h28
`define CADC_IDX_IRQ_ST 6'h29
`define CADC_IDX_IRQ_MASK 6'h2A

// per-channel nibble of the flag register
`define CADC_LEFT_NIB 4
`define CADC_RIGHT_NIB 0
`define CADC_F_SETTLED 3
`define CADC_F_POWERED 2
`define CADC_F_QUIET 1
`define CADC_F_SATURATED 0

// power and left companion register
`define CADC_PWR_DACL 7
`define CADC_PWR_DACR 6
`define CADC_PWR_LCOMP 4
`define CADC_PWR_WMASK 8'hF0

// driver and protection register
`define CADC_DRV_RCOMP 3
`define CADC_DRV_SCP_EN 2
`define CADC_DRV_SCP_MODE 1
`define CADC_DRV_WMASK 8'h3E

// output stage register; the low two bits stay zero here
`define CADC_STG_VCM 6
`define CADC_STG_BYPL 4
`define CADC_STG_BYPR 2
`define CADC_STG_WMASK 8'hFC

`define CADC_RST_8 8'h00
`define CADC_RST_IRQ 12'h000
`define CADC_IRQ_DRV_LSB 8
`define CADC_N_DRV 4

`endif

//--- hdl/cadc_pkg.sv
// types shared by the codec register bank modules
`default_nettype none

package cadc_pkg;
    typedef enum logic [1:0] {LC_DIFF, LC_CM, LC_SE, LC_RSVD} cadc_lcomp_e;
    typedef enum logic [2:0] {RC_DIFF, RC_CM, RC_SE, RC_DIFF_LC, RC_EXT_FB, RC_RSVD} cadc_rcomp_e;
    typedef enum logic [1:0] {BYP_OFF, BYP_POS, BYP_NEG, BYP_DIFF} cadc_byp_e;
    typedef enum logic [1:0] {CM_1V35, CM_1V50, CM_1V65, CM_1V80} cadc_vcm_e;
    typedef logic [7:0] cadc_byte_t;
endpackage

`default_nettype wire

//--- hdl/cadc_chan_if.sv
// analog-side status inputs and derived flags of one recording channel
`default_nettype none

interface cadc_chan_if;
    cadc_pkg::cadc_byte_t applied_gain;
    cadc_pkg::cadc_byte_t prog_gain;
    logic adc_powered;
    cadc_pkg::cadc_byte_t sig_power;
    cadc_pkg::cadc_byte_t noise_thresh;
    cadc_pkg::cadc_byte_t agc_gain;
    cadc_pkg::cadc_byte_t agc_max;
    logic [3:0] flags;

    modport src (output applied_gain, prog_gain, adc_powered, sig_power,
                 output noise_thresh, agc_gain, agc_max, input flags);
    modport mon (input applied_gain, prog_gain, adc_powered, sig_power,
                 input noise_thresh, agc_gain, agc_max, output flags);
endinterface

`default_nettype wire

//--- hdl/cadc_chan_status.sv
// per-channel status flags: gain settled, powered, quiet, agc saturated
`include "cadc_params.svh"
`default_nettype none

module cadc_chan_status (
    input wire logic clk_i, // control clock
    input wire logic rst_i, // synchronous reset
    cadc_chan_if.mon ch // channel status
);
    logic [3:0] flags;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags <= 4'h0;
        end else begin
            flags[`CADC_F_SETTLED] <= (ch.applied_gain == ch.prog_gain);
            flags[`CADC_F_POWERED] <= ch.adc_powered;
            flags[`CADC_F_QUIET] <= (ch.sig_power < ch.noise_thresh);
            flags[`CADC_F_SATURATED] <= (ch.agc_gain == ch.agc_max);
        end
    end

    assign ch.flags = flags;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_gain_settled: assert property ((ch.applied_gain != ch.prog_gain) |=> !ch.flags[3])
        else $error("settled flag set while gains differ");
    a_power_status: assert property (ch.adc_powered |=> ch.flags[2])
        else $error("power flag missing while adc powered");
    a_quiet_flag: assert property ((ch.sig_power < ch.noise_thresh) |=> ch.flags[1])
        else $error("quiet flag missing below threshold");
    a_agc_saturation: assert property ((ch.agc_gain != ch.agc_max) |=> !ch.flags[0])
        else $error("saturation flag set below maximum");
    a_gain_match: assert property ((ch.applied_gain == ch.prog_gain) |=> ch.flags[3])
        else $error("settled flag missing while gains match");
    a_power_down: assert property (!ch.adc_powered |=> !ch.flags[2])
        else $error("power flag set while adc powered down");
    a_loud_clear: assert property ((ch.sig_power >= ch.noise_thresh) |=> !ch.flags[1])
        else $error("quiet flag set at or above threshold");
    a_agc_at_max: assert property ((ch.agc_gain == ch.agc_max) |=> ch.flags[0])
        else $error("saturation flag missing at maximum");
endmodule

`default_nettype wire

//--- hdl/cadc_regs.sv
// codec adc status and output control registers behind a wishbone slave
//
// Design decision made here: the Wishbone slave port.
`include "cadc_params.svh"
`default_nettype none

// What this block does
// - flag gain settled when applied equals programmed
// - flag each recording converter's power state
// - flag signal power below noise threshold
// - flag agc loop at maximum gain
// - power bits switch playback converters on
// - decode left companion driver mode field
// - decode right companion driver mode field
// - one bit enables all short protection
// - mode bit picks current limit or shutdown
// - select output common-mode level
// - control left second-line bypass path
// - control right second-line bypass path
// - status register resets zero, read only
module cadc_regs (
    input wire logic clk_i, // control clock, 100 MHz
    input wire logic rst_i, // synchronous reset, high
    input wire logic cyc_i, // wishbone cycle
    input wire logic stb_i, // wishbone strobe
    input wire logic we_i, // wishbone write
    input wire logic [7:0] adr_i, // wishbone byte address
    input wire logic [3:0] sel_i, // wishbone byte select
    input wire logic [31:0] dat_i, // wishbone write data
    output logic [31:0] dat_o, // wishbone read data
    output logic ack_o, // wishbone acknowledge
    output logic irq_o, // level interrupt
    input wire logic [1:0][7:0] applied_gain_i, // gain applied, [1] left
    input wire logic [1:0][7:0] prog_gain_i, // gain programmed
    input wire logic [1:0] adc_powered_i, // recording converter powered
    input wire logic [1:0][7:0] sig_power_i, // measured signal power
    input wire logic [1:0][7:0] noise_thresh_i, // noise threshold
    input wire logic [1:0][7:0] agc_gain_i, // agc gain now
    input wire logic [1:0][7:0] agc_max_i, // agc gain limit
    input wire logic [3:0] short_detect_i, // short seen per driver
    output logic [1:0] dac_power_o, // playback converter on, [1] left
    output cadc_pkg::cadc_lcomp_e left_companion_mode_o, // left companion driver
    output cadc_pkg::cadc_rcomp_e right_companion_mode_o, // right companion driver
    output logic short_protect_en_o, // protection on all drivers
    output logic current_limit_o, // protection limits current
    output logic [3:0] driver_off_o, // driver forced down by short
    output cadc_pkg::cadc_vcm_e common_mode_level_o, // output common mode
    output cadc_pkg::cadc_byp_e left_bypass_o, // left second-line bypass
    output cadc_pkg::cadc_byp_e right_bypass_o // right second-line bypass
);
    logic [7:0] adc_flags;
    logic [7:0] prev_flags;
    cadc_pkg::cadc_byte_t pwr_reg;
    cadc_pkg::cadc_byte_t drv_reg;
    cadc_pkg::cadc_byte_t stage_reg;
    logic [11:0] irq_st;
    logic [11:0] irq_mask;
    logic [11:0] irq_set;
    logic [3:0] next_driver_off;
    logic req;
    logic wr_en;
    logic [31:0] next_dat;

    function automatic logic hit(input logic [7:0] adr, input logic [5:0] idx);
        hit = (adr[7:2] == idx);
    endfunction

    function automatic cadc_pkg::cadc_byp_e dec_byp(input logic [1:0] f);
        unique case (f)
            2'b00: dec_byp = cadc_pkg::BYP_OFF;
            2'b01: dec_byp = cadc_pkg::BYP_POS;
            2'b10: dec_byp = cadc_pkg::BYP_NEG;
            2'b11: dec_byp = cadc_pkg::BYP_DIFF;
        endcase
    endfunction

    function automatic cadc_pkg::cadc_rcomp_e dec_rcomp(input logic [2:0] f);
        unique case (f)
            3'b000: dec_rcomp = cadc_pkg::RC_DIFF;
            3'b001: dec_rcomp = cadc_pkg::RC_CM;
            3'b010: dec_rcomp = cadc_pkg::RC_SE;
            3'b011: dec_rcomp = cadc_pkg::RC_DIFF_LC;
            3'b100: dec_rcomp = cadc_pkg::RC_EXT_FB;
            default: dec_rcomp = cadc_pkg::RC_RSVD;
        endcase
    endfunction

    // channel status: index 1 left (high nibble), 0 right
    cadc_chan_if ch_if[2] ();

    for (genvar g = 0; g < 2; g++) begin : g_chan
        assign ch_if[g].applied_gain = applied_gain_i[g];
        assign ch_if[g].prog_gain = prog_gain_i[g];
        assign ch_if[g].adc_powered = adc_powered_i[g];
        assign ch_if[g].sig_power = sig_power_i[g];
        assign ch_if[g].noise_thresh = noise_thresh_i[g];
        assign ch_if[g].agc_gain = agc_gain_i[g];
        assign ch_if[g].agc_max = agc_max_i[g];
        assign adc_flags[g*4 +: 4] = ch_if[g].flags;

        cadc_chan_status u_chan (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .ch(ch_if[g].mon)
        );
    end

    // bus: one wait state, then ack for exactly one cycle
    assign req = cyc_i & stb_i;
    assign wr_en = req & we_i & ack_o & sel_i[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= req & ~ack_o;
        end
    end

    always_comb begin
        next_dat = 32'h0000_0000;
        if (hit(adr_i, `CADC_IDX_FLAGS)) begin
            next_dat[7:0] = adc_flags;
        end else if (hit(adr_i, `CADC_IDX_PWR)) begin
            next_dat[7:0] = pwr_reg;
        end else if (hit(adr_i, `CADC_IDX_DRV)) begin
            next_dat[7:0] = drv_reg;
        end else if (hit(adr_i, `CADC_IDX_STAGE)) begin
            next_dat[7:0] = stage_reg;
        end else if (hit(adr_i, `CADC_IDX_IRQ_ST)) begin
            next_dat[11:0] = irq_st;
        end else if (hit(adr_i, `CADC_IDX_IRQ_MASK)) begin
            next_dat[11:0] = irq_mask;
        end
    end

    // reserved slot and unmapped addresses read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (req & ~ack_o & ~we_i) begin
            dat_o <= next_dat;
        end
    end

    // reserved positions are masked so they always read zero;
    // writes to the flag register and the reserved slot have no path
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwr_reg <= `CADC_RST_8;
        end else if (wr_en & hit(adr_i, `CADC_IDX_PWR)) begin
            pwr_reg <= dat_i[7:0] & `CADC_PWR_WMASK;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drv_reg <= `CADC_RST_8;
        end else if (wr_en & hit(adr_i, `CADC_IDX_DRV)) begin
            drv_reg <= dat_i[7:0] & `CADC_DRV_WMASK;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stage_reg <= `CADC_RST_8;
        end else if (wr_en & hit(adr_i, `CADC_IDX_STAGE)) begin
            stage_reg <= dat_i[7:0] & `CADC_STG_WMASK;
        end
    end

    // decoded controls, registered from the control bytes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dac_power_o <= 2'b00;
            left_companion_mode_o <= cadc_pkg::LC_DIFF;
            right_companion_mode_o <= cadc_pkg::RC_DIFF;
            common_mode_level_o <= cadc_pkg::CM_1V35;
            left_bypass_o <= cadc_pkg::BYP_OFF;
            right_bypass_o <= cadc_pkg::BYP_OFF;
        end else begin
            dac_power_o <= {pwr_reg[`CADC_PWR_DACL], pwr_reg[`CADC_PWR_DACR]};
            left_companion_mode_o <= cadc_pkg::cadc_lcomp_e'(pwr_reg[`CADC_PWR_LCOMP +: 2]);
            // reserved codes map to a parked state, never to a drive mode
            right_companion_mode_o <= dec_rcomp(drv_reg[`CADC_DRV_RCOMP +: 3]);
            common_mode_level_o <= cadc_pkg::cadc_vcm_e'(stage_reg[`CADC_STG_VCM +: 2]);
            left_bypass_o <= dec_byp(stage_reg[`CADC_STG_BYPL +: 2]);
            right_bypass_o <= dec_byp(stage_reg[`CADC_STG_BYPR +: 2]);
        end
    end

    // short protection; a latched shutdown holds until protection or
    // shutdown mode is switched off, so a driver does not chatter on a short
    always_comb begin
        next_driver_off = driver_off_o;
        if (!drv_reg[`CADC_DRV_SCP_EN] || !drv_reg[`CADC_DRV_SCP_MODE]) begin
            next_driver_off = 4'h0;
        end else begin
            next_driver_off = driver_off_o | short_detect_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            short_protect_en_o <= 1'b0;
            current_limit_o <= 1'b0;
            driver_off_o <= 4'h0;
        end else begin
            short_protect_en_o <= drv_reg[`CADC_DRV_SCP_EN];
            current_limit_o <= drv_reg[`CADC_DRV_SCP_EN] & ~drv_reg[`CADC_DRV_SCP_MODE];
            driver_off_o <= next_driver_off;
        end
    end

    // interrupts: rising status flags and new driver shutdowns
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_flags <= `CADC_RST_8;
        end else begin
            prev_flags <= adc_flags;
        end
    end

    assign irq_set = {next_driver_off & ~driver_off_o, adc_flags & ~prev_flags};

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_st <= `CADC_RST_IRQ;
        end else if (wr_en & hit(adr_i, `CADC_IDX_IRQ_ST)) begin
            irq_st <= (irq_st & ~dat_i[11:0]) | irq_set;
        end else begin
            irq_st <= irq_st | irq_set;
        end
    end

    // mask spans two byte lanes; each lane is honoured on its own
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask <= `CADC_RST_IRQ;
        end else if (req & we_i & ack_o & hit(adr_i, `CADC_IDX_IRQ_MASK)) begin
            if (sel_i[0]) begin
                irq_mask[7:0] <= dat_i[7:0];
            end
            if (sel_i[1]) begin
                irq_mask[11:8] <= dat_i[11:8];
            end
        end
    end

    assign irq_o = |(irq_st & irq_mask);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    a_dac_power: assert property (wr_en && hit(adr_i, 6'h25) |=> ##1
        dac_power_o == $past(dat_i[7:6], 2))
        else $error("playback power does not follow write");
    a_left_comp: assert property (pwr_reg[5:4] == 2'b01 |=> left_companion_mode_o == cadc_pkg::LC_CM)
        else $error("left companion not constant common mode");
    a_right_comp: assert property (drv_reg[5:3] == 3'b100 |=> right_companion_mode_o == cadc_pkg::RC_EXT_FB)
        else $error("right companion not external feedback");
    a_scp_off: assert property (!drv_reg[2] |=> driver_off_o == 4'h0 && !short_protect_en_o)
        else $error("protection active while disabled");
    a_scp_shutdown: assert property (drv_reg[2] && drv_reg[1] && short_detect_i[0] |=>
        driver_off_o[0] && !current_limit_o)
        else $error("driver not powered down on short");
    a_scp_limit: assert property (drv_reg[2] && !drv_reg[1] |=> current_limit_o && driver_off_o == 4'h0)
        else $error("current limit mode not applied");
    a_vcm_level: assert property (stage_reg[7:6] == 2'b11 |=> common_mode_level_o == cadc_pkg::CM_1V80)
        else $error("common mode level not 1.8 V");
    a_bypass_left: assert property (stage_reg[5:4] == 2'b10 |=> left_bypass_o == cadc_pkg::BYP_NEG)
        else $error("left bypass not negative input");
    a_bypass_right: assert property (stage_reg[3:2] == 2'b11 |=> right_bypass_o == cadc_pkg::BYP_DIFF)
        else $error("right bypass not differential");
    a_flags_reset: assert property (disable iff (1'b0) rst_i |=> adc_flags == 8'h00)
        else $error("status flags not zero after reset");
    a_rsvd_reads: assert property (req && !ack_o && !we_i && hit(adr_i, 6'h27) |=>
        ack_o && dat_o == 32'h0000_0000)
        else $error("reserved slot read not zero");
    a_irq_sticky: assert property (irq_st[0] && !(wr_en && hit(adr_i, 6'h29) && dat_i[0]) |=> irq_st[0])
        else $error("status bit lost without clear");

    // bus handshake, read path and write masking
    a_ack_answer: assert property (req && !ack_o |=>
        ack_o)
        else $error("request not answered one cycle later");
    a_flag_read: assert property (req && !ack_o && !we_i && hit(adr_i, 6'h24) |=>
        dat_o == {24'h00_0000, $past(adc_flags)})
        else $error("flag read does not return the flags");
    a_dat_hold: assert property (!(req && !ack_o && !we_i) |=>
        $stable(dat_o))
        else $error("read data changed without a read");
    a_ro_writes: assert property (wr_en && (hit(adr_i, 6'h24) || hit(adr_i, 6'h27)) |=>
        $stable(pwr_reg) && $stable(drv_reg) && $stable(stage_reg))
        else $error("write to read-only slot changed a register");
    a_drv_write: assert property (wr_en && hit(adr_i, 6'h26) |=>
        drv_reg == ($past(dat_i[7:0]) & 8'h3E))
        else $error("driver byte not written through its mask");
    a_mask_write: assert property (req && we_i && ack_o && sel_i[0] && hit(adr_i, 6'h2A) |=>
        irq_mask[7:0] == $past(dat_i[7:0]))
        else $error("interrupt mask low lane not written");
    // control decode, protection and interrupt status
    a_left_comp_se: assert property (pwr_reg[5:4] == 2'b10 |=>
        left_companion_mode_o == cadc_pkg::LC_SE)
        else $error("left companion not single ended");
    a_right_comp_dl: assert property (drv_reg[5:3] == 3'b011 |=>
        right_companion_mode_o == cadc_pkg::RC_DIFF_LC)
        else $error("right companion not differential of left");
    a_vcm_low: assert property (stage_reg[7:6] == 2'b00 |=>
        common_mode_level_o == cadc_pkg::CM_1V35)
        else $error("common mode level not 1.35 V");
    a_bypass_ldiff: assert property (stage_reg[5:4] == 2'b11 |=>
        left_bypass_o == cadc_pkg::BYP_DIFF)
        else $error("left bypass not differential");
    a_bypass_rpos: assert property (stage_reg[3:2] == 2'b01 |=>
        right_bypass_o == cadc_pkg::BYP_POS)
        else $error("right bypass not positive input");
    a_scp_enable: assert property (drv_reg[2] |=>
        short_protect_en_o)
        else $error("protection not enabled");
    a_scp_latch: assert property (drv_reg[2] && drv_reg[1] && driver_off_o[2] |=>
        driver_off_o[2])
        else $error("driver shutdown released while latched");
    a_irq_set_wins: assert property (irq_set != 12'h000 |=>
        (irq_st & $past(irq_set)) == $past(irq_set))
        else $error("status event lost");
    a_irq_clear: assert property (wr_en && hit(adr_i, 6'h29) && dat_i[0] && !irq_set[0] |=>
        !irq_st[0])
        else $error("status bit not cleared by write of one");

    c_pwr_write: cover property (wr_en && hit(adr_i, 6'h25));
    c_shutdown: cover property ($rose(driver_off_o[0]));
    c_irq_rise: cover property ($rose(irq_o));
    c_flag_read: cover property (ack_o && !we_i && hit(adr_i, 6'h24));
    c_ext_feedback: cover property (right_companion_mode_o == cadc_pkg::RC_EXT_FB);
endmodule

`default_nettype wire

//--- sim/tb_codec_adc_status_output_ctrl_regs.sv
// self-checking bench for the codec status and output control register bank
`default_nettype none

module tb_codec_adc_status_output_ctrl_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o;
    logic [7:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o, rd;
    logic [1:0][7:0] applied_gain_i, prog_gain_i, sig_power_i, noise_thresh_i, agc_gain_i, agc_max_i;
    logic [1:0] adc_powered_i, dac_power_o;
    logic [3:0] short_detect_i, driver_off_o;
    cadc_pkg::cadc_lcomp_e left_companion_mode_o;
    cadc_pkg::cadc_rcomp_e right_companion_mode_o;
    logic short_protect_en_o, current_limit_o;
    cadc_pkg::cadc_vcm_e common_mode_level_o;
    cadc_pkg::cadc_byp_e left_bypass_o, right_bypass_o;
    int num_errors, n_checks;
    logic [7:0] p94, p98, pa0;
    // address, write data, expected readback; legal codes only, reserved bits zero
    logic [23:0] rows [12] = '{24'h94_8080, 24'h94_5050, 24'h94_E0E0, 24'h98_0000, 24'h98_0C0C,
        24'h98_1616, 24'h98_1A1A, 24'h98_2020, 24'hA0_0000, 24'hA0_5454, 24'hA0_A8A8, 24'hA0_FCFC};
    logic [7:0] fvals [4] = '{8'hF0, 8'h0F, 8'hA5, 8'h5A};

    cadc_regs uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
        .applied_gain_i(applied_gain_i), .prog_gain_i(prog_gain_i), .adc_powered_i(adc_powered_i),
        .sig_power_i(sig_power_i), .noise_thresh_i(noise_thresh_i), .agc_gain_i(agc_gain_i),
        .agc_max_i(agc_max_i), .short_detect_i(short_detect_i), .dac_power_o(dac_power_o),
        .left_companion_mode_o(left_companion_mode_o), .right_companion_mode_o(right_companion_mode_o),
        .short_protect_en_o(short_protect_en_o), .current_limit_o(current_limit_o),
        .driver_off_o(driver_off_o), .common_mode_level_o(common_mode_level_o),
        .left_bypass_o(left_bypass_o), .right_bypass_o(right_bypass_o));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one classic cycle; the request stays up until ack is sampled at a rising edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hF;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        check("ack_wait", n, 2);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d, rd);
    endtask

    task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0, rd);
        check(name, rd, e);
    endtask

    // equality and strict-less boundaries are used so a flipped compare shows up
    task automatic set_flags(input logic [7:0] f);
        for (int c = 0; c < 2; c++) begin
            applied_gain_i[c] <= 8'h10;
            prog_gain_i[c] <= f[4*c+3] ? 8'h10 : 8'h0F;
            adc_powered_i[c] <= f[4*c+2];
            sig_power_i[c] <= 8'h20;
            noise_thresh_i[c] <= f[4*c+1] ? 8'h21 : 8'h20;
            agc_gain_i[c] <= 8'h30;
            agc_max_i[c] <= f[4*c] ? 8'h30 : 8'h31;
        end
        repeat (3) @(posedge clk_i);
    endtask

    task automatic check_outs();
        check("dac_power", dac_power_o, p94[7:6]);
        check("left_comp", left_companion_mode_o, p94[5:4]);
        check("right_comp", right_companion_mode_o, p98[5:3]);
        check("scp_en", short_protect_en_o, p98[2]);
        check("cur_limit", current_limit_o, p98[2] & ~p98[1]);
        check("vcm", common_mode_level_o, pa0[7:6]);
        check("byp_l", left_bypass_o, pa0[5:4]);
        check("byp_r", right_bypass_o, pa0[3:2]);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #50000;
        num_errors++;
        end_of_test();
    end

    initial begin
        {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i, short_detect_i} = '0;
        {applied_gain_i, prog_gain_i, sig_power_i, noise_thresh_i, agc_gain_i, agc_max_i} = '0;
        adc_powered_i = '0;
        rst_i = 1'b1;
        {p94, p98, pa0} = '0;
        set_flags(8'h00);
        rst_i <= 1'b0;
        check("ack_rst", ack_o, 0);
        check("dat_rst", dat_o, 0);
        check_outs();
        for (int i = 0; i < 7; i++) rdc("reset_value", 8'h90 + 8'(4 * i), 0);
        $display("test reset done");
        foreach (rows[i]) begin
            wr(rows[i][23:16], rows[i][15:8]);
            case (rows[i][23:16])
                8'h94: p94 = rows[i][15:8];
                8'h98: p98 = rows[i][15:8];
                8'hA0: pa0 = rows[i][15:8];
                default: ;
            endcase
            rdc("readback", rows[i][23:16], rows[i][7:0]);
            check_outs();
        end
        $display("test control rows done");
        foreach (fvals[i]) begin
            set_flags(fvals[i]);
            rdc("flags", 8'h90, fvals[i]);
        end
        wr(8'h90, 8'hFF);
        rdc("flags_ro", 8'h90, 8'h5A);
        rdc("reserved_reg", 8'h9C, 0);
        wr(8'hB0, 8'h5A);
        rdc("unmapped", 8'hB0, 0);
        $display("test flags done");
        set_flags(8'h00);
        wr(8'hA4, 12'hFFF);
        rdc("irq_clear", 8'hA4, 0);
        set_flags(8'hF0);
        rdc("irq_set", 8'hA4, 8'hF0);
        check("irq_masked", irq_o, 0);
        wr(8'hA8, 12'h010);
        repeat (2) @(posedge clk_i);
        check("irq_on", irq_o, 1);
        wr(8'hA4, 12'h010);
        repeat (2) @(posedge clk_i);
        check("irq_off", irq_o, 0);
        rdc("irq_w1c", 8'hA4, 8'hE0);
        wr(8'hA4, 12'h0E0);
        $display("test interrupt done");
        wr(8'h98, 8'h06);
        p98 = 8'h06;
        short_detect_i <= 4'b0101;
        repeat (3) @(posedge clk_i);
        check("drv_off", driver_off_o, 4'b0101);
        short_detect_i <= 4'b0000;
        repeat (3) @(posedge clk_i);
        check("drv_latch", driver_off_o, 4'b0101);
        rdc("irq_drv", 8'hA4, 12'h500);
        wr(8'hA8, 12'h100);
        repeat (2) @(posedge clk_i);
        check("irq_drv_on", irq_o, 1);
        wr(8'h98, 8'h04);
        p98 = 8'h04;
        repeat (2) @(posedge clk_i);
        check("drv_release", driver_off_o, 0);
        check_outs();
        wr(8'h98, 8'h02);
        p98 = 8'h02;
        short_detect_i <= 4'b1111;
        repeat (3) @(posedge clk_i);
        check("drv_no_prot", driver_off_o, 0);
        check_outs();
        $display("test protection done");
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        check("mid_rst_dat", dat_o, 0);
        check("mid_rst_irq", irq_o, 0);
        check("mid_rst_off", driver_off_o, 0);
        rst_i <= 1'b0;
        {p94, p98, pa0} = '0;
        @(posedge clk_i);
        check_outs();
        rdc("rst_pwr", 8'h94, 0);
        $display("test second reset done");
        end_of_test();
    end
endmodule

`default_nettype wire
